// ===== design/sram_host.v
// host controller that performs single reads and writes on the static memory
`timescale 1ns/1ps
`include "sram_host_defines.vh"
module sram_host (
   input  wire                 mclk_in,
   input  wire                 rst_n_in,
   input  wire                 req_in,
   input  wire                 req_write_in,
   input  wire [`ADDR_W-1:0]   req_addr_in,
   input  wire [`DATA_W-1:0]   req_wdata_in,
   output reg                  busy_out,
   output reg                  done_out,
   output reg  [`DATA_W-1:0]   rdata_out,
   output reg  [`ADDR_W-1:0]   word_address_out,
   output reg                  select_n_out,
   output reg                  write_n_out,
   output reg                  drive_n_out,
   input  wire [`DATA_W-1:0]   byte_data_pins_in,
   output reg  [`DATA_W-1:0]   byte_data_pins_out,
   output reg                  byte_data_pins_oe_out
);
   // access sequencer states
   localparam [2:0] ST_IDLE  = 3'h0;
   localparam [2:0] ST_READ  = 3'h1;
   localparam [2:0] ST_FLOAT = 3'h2;
   localparam [2:0] ST_WRITE = 3'h3;
   localparam [2:0] ST_END   = 3'h4;
   localparam [2:0] ST_DONE  = 3'h5;

   // whole-cycle waits; four bits hold every wait used here
   localparam integer READ_CYC_I  = `READ_CYC;
   localparam integer FLOAT_CYC_I = `FLOAT_CYC;
   localparam integer WRITE_CYC_I = `WRITE_CYC;
   localparam [3:0]   READ_CNT    = READ_CYC_I[3:0];
   localparam [3:0]   FLOAT_CNT   = FLOAT_CYC_I[3:0];
   localparam [3:0]   WRITE_CNT   = WRITE_CYC_I[3:0];
   // last count of each wait; a read adds three cycles for the synchroniser
   localparam [3:0]   READ_LAST   = READ_CNT + 4'h2;
   localparam [3:0]   FLOAT_LAST  = FLOAT_CNT - 4'h1;
   localparam [3:0]   WRITE_LAST  = WRITE_CNT - 4'h1;

   // true on the last cycle of a wait
   function count_hit;
      input [3:0] count;
      input [3:0] last;
      begin
         count_hit = (count == last);
      end
   endfunction

   // next wait count; no wait here is long enough to wrap
   function [3:0] count_step;
      input [3:0] count;
      begin
         count_step = count + 4'h1;
      end
   endfunction

   // sequencer state and wait counter
   reg [2:0]         state_reg;
   reg [2:0]         state_next;
   reg [3:0]         count_reg;
   reg [3:0]         count_next;
   // pin synchroniser
   reg [`DATA_W-1:0] pin_meta_reg;
   reg [`DATA_W-1:0] pin_sync_reg;
   // next values of the output flops
   reg               busy_next;
   reg               done_next;
   reg [`DATA_W-1:0] rdata_next;
   reg [`ADDR_W-1:0] address_next;
   reg               select_n_next;
   reg               write_n_next;
   reg               drive_n_next;
   reg [`DATA_W-1:0] wdata_next;
   reg               data_oe_next;

   // pins pass two flops; wait counts cover the extra latency
   always @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         pin_meta_reg <= `DATA_RESET;
         pin_sync_reg <= `DATA_RESET;
      end else begin
         pin_meta_reg <= byte_data_pins_in;
         pin_sync_reg <= pin_meta_reg;
      end
   end

   // sequencer flops
   always @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         state_reg <= ST_IDLE;
         count_reg <= `COUNT_RESET;
      end else begin
         state_reg <= state_next;
         count_reg <= count_next;
      end
   end

   // output flops; every pin comes straight from a register
   always @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         busy_out              <= 1'b0;
         done_out              <= 1'b0;
         rdata_out             <= `DATA_RESET;
         word_address_out      <= `ADDR_RESET;
         select_n_out          <= 1'b1;
         write_n_out           <= 1'b1;
         drive_n_out           <= 1'b1;
         byte_data_pins_out    <= `DATA_RESET;
         byte_data_pins_oe_out <= 1'b0;
      end else begin
         busy_out              <= busy_next;
         done_out              <= done_next;
         rdata_out             <= rdata_next;
         word_address_out      <= address_next;
         select_n_out          <= select_n_next;
         write_n_out           <= write_n_next;
         drive_n_out           <= drive_n_next;
         byte_data_pins_out    <= wdata_next;
         byte_data_pins_oe_out <= data_oe_next;
      end
   end

   // next-value decode, one access at a time
   always @* begin
      // hold everything but done, which drops, unless the current state moves it
      state_next    = state_reg;
      count_next    = count_reg;
      busy_next     = busy_out;
      done_next     = 1'b0;
      rdata_next    = rdata_out;
      address_next  = word_address_out;
      select_n_next = select_n_out;
      write_n_next  = write_n_out;
      drive_n_next  = drive_n_out;
      wdata_next    = byte_data_pins_out;
      data_oe_next  = byte_data_pins_oe_out;

      // each state moves only the pins it owns
      case (state_reg)
         ST_IDLE: begin
            // request fields are taken only here; later changes are ignored
            if (req_in) begin
               busy_next     = 1'b1;
               address_next  = req_addr_in;
               select_n_next = 1'b0;
               count_next    = `COUNT_RESET;
               if (req_write_in) begin
                  // address valid with strobe: zero setup allowed
                  write_n_next = 1'b0;
                  drive_n_next = 1'b1;
                  wdata_next   = req_wdata_in;
                  state_next   = ST_FLOAT;
               end else begin
                  drive_n_next = 1'b0;
                  state_next   = ST_READ;
               end
            end
         end

         ST_READ: begin
            // wait covers access time plus the synchroniser
            if (count_hit(count_reg, READ_LAST)) begin
               rdata_next    = pin_sync_reg;
               select_n_next = 1'b1;
               drive_n_next  = 1'b1;
               count_next    = `COUNT_RESET;
               state_next    = ST_END;
            end else begin
               count_next = count_step(count_reg);
            end
         end

         ST_FLOAT: begin
            // wait for device release before driving data
            if (count_hit(count_reg, FLOAT_LAST)) begin
               data_oe_next = 1'b1;
               count_next   = `COUNT_RESET;
               state_next   = ST_WRITE;
            end else begin
               count_next = count_step(count_reg);
            end
         end

         ST_WRITE: begin
            // data setup fits inside the pulse, so pulse count governs
            if (count_hit(count_reg, WRITE_LAST)) begin
               write_n_next  = 1'b1;
               select_n_next = 1'b1;
               count_next    = `COUNT_RESET;
               state_next    = ST_END;
            end else begin
               count_next = count_step(count_reg);
            end
         end

         ST_END: begin
            // data held one cycle past the end edge, then released
            data_oe_next = 1'b0;
            state_next   = ST_DONE;
         end

         ST_DONE: begin
            // one idle cycle also covers float after deselect
            busy_next  = 1'b0;
            done_next  = 1'b1;
            state_next = ST_IDLE;
         end

         default: begin
            // lost state releases the bus rather than guess at an access
            state_next    = ST_IDLE;
            count_next    = `COUNT_RESET;
            busy_next     = 1'b0;
            select_n_next = 1'b1;
            write_n_next  = 1'b1;
            drive_n_next  = 1'b1;
            data_oe_next  = 1'b0;
         end
      endcase
   end
endmodule // sram_host

// ===== design/sram_host_defines.vh
// timing and field constants for the static memory host controller
// Overview of operation
// - select low 13 ns before write end
// - address stable 13 ns before write end
// - write data 9 ns setup, 0 ns hold
// - host never drives against the device
`ifndef SRAM_HOST_DEFINES_VH
`define SRAM_HOST_DEFINES_VH
`define ADDR_W            14
`define DATA_W            8
`define ADDR_RESET        14'h0000
`define DATA_RESET        8'h00
`define COUNT_RESET       4'h0
`define CLK_PERIOD_NS     20
// slow-grade figures in ns, valid for both grades
`define SELECT_TO_DATA_NS 15
`define FLOAT_NS          8
`define WRITE_PULSE_NS    13
`define DATA_SETUP_NS     9
// least times round up to whole cycles, at least one
`define CEIL_CYC(t)       (((t) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define READ_CYC          `CEIL_CYC(`SELECT_TO_DATA_NS)
`define FLOAT_CYC         `CEIL_CYC(`FLOAT_NS)
`define WRITE_CYC         `CEIL_CYC(`WRITE_PULSE_NS)
`define SETUP_CYC         `CEIL_CYC(`DATA_SETUP_NS)
`endif

// ===== verification/sram_host_properties.sv
// pin timing assertions for the static memory host controller
`timescale 1ns/1ps
`include "sram_host_defines.vh"
module sram_host_properties (
   input wire                mclk_in, rst_n_in, done_out, select_n_out,
   input wire                write_n_out, drive_n_out, byte_data_pins_oe_out,
   input wire [`ADDR_W-1:0]  word_address_out,
   input wire [`DATA_W-1:0]  byte_data_pins_out
);
   default clocking @(posedge mclk_in); endclocking
   default disable iff (!rst_n_in);
   // write strobe low two cycles, data driven only in the second
   sequence write_pulse;
      (!write_n_out && !select_n_out) ##1 (!write_n_out && byte_data_pins_oe_out);
   endsequence
   // read covers the access time plus the synchroniser
   sequence read_pulse;
      (!select_n_out && !drive_n_out)[*4];
   endsequence
   chk_write_shape: assert property ($fell(write_n_out) |-> write_pulse ##1 (write_n_out && select_n_out)) else $error("write strobe shape");
   chk_read_shape: assert property ($fell(drive_n_out) |-> read_pulse ##1 select_n_out) else $error("read strobe shape");
   chk_no_fight: assert property (byte_data_pins_oe_out |-> drive_n_out) else $error("host drives while memory enabled");
   chk_data_hold: assert property ($rose(write_n_out) |-> byte_data_pins_oe_out && $stable(byte_data_pins_out)) else $error("write data not held");
   chk_addr_stable: assert property (!select_n_out && !$past(select_n_out) |-> $stable(word_address_out)) else $error("address moved");
   chk_bus_release: assert property ($rose(write_n_out) |=> !byte_data_pins_oe_out) else $error("pins not released");
   chk_read_done: assert property ($rose(drive_n_out) |-> ##2 done_out) else $error("read done late");
   chk_done_once: assert property (done_out |=> !done_out) else $error("done longer than one cycle");
endmodule // sram_host_properties
bind sram_host sram_host_properties chk (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .done_out(done_out),
   .select_n_out(select_n_out), .write_n_out(write_n_out), .drive_n_out(drive_n_out),
   .byte_data_pins_oe_out(byte_data_pins_oe_out), .word_address_out(word_address_out),
   .byte_data_pins_out(byte_data_pins_out));

// ===== verification/sram_host_tb.sv
// self-checking bench for the static memory host controller
`timescale 1ns/1ps
module sram_host_tb;
   reg         mclk_in = 0, rst_n_in = 0, req_in = 0, req_write_in = 0;
   reg  [13:0] req_addr_in = 0;
   reg  [7:0]  req_wdata_in = 0;
   wire        busy_out, done_out, select_n_out, write_n_out, drive_n_out, oe;
   wire [13:0] word_address_out;
   wire [7:0]  rdata_out, pins_out, mem_q, pins;
   integer     errors = 0, num_checks = 0;
   assign pins = oe ? pins_out : mem_q; // resolved data wire
   always #10 mclk_in = ~mclk_in;
   sram_host DUT (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .req_in(req_in),
      .req_write_in(req_write_in), .req_addr_in(req_addr_in), .req_wdata_in(req_wdata_in),
      .busy_out(busy_out), .done_out(done_out), .rdata_out(rdata_out),
      .word_address_out(word_address_out), .select_n_out(select_n_out),
      .write_n_out(write_n_out), .drive_n_out(drive_n_out), .byte_data_pins_in(pins),
      .byte_data_pins_out(pins_out), .byte_data_pins_oe_out(oe));
   sram_model mem (.word_address_in(word_address_out), .select_n_in(select_n_out),
      .write_n_in(write_n_out), .drive_n_in(drive_n_out), .data_in(pins), .data_out(mem_q));
   task check(input string what, input logic [7:0] exp, input logic [7:0] got);
      num_checks++;
      if (got !== exp) begin
         errors++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask
   // request held high until the given number of done pulses
   task access(input logic w, input logic [13:0] a, input logic [7:0] d, input integer dones);
      integer t;
      @(negedge mclk_in);
      {req_in, req_write_in, req_addr_in, req_wdata_in} = {1'b1, w, a, d};
      for (t = 0; t < 40 && dones > 0; t++) begin
         @(negedge mclk_in);
         if (done_out === 1'b1) dones--;
      end
      req_in = 0;
      check("done pulses left", 8'h00, dones[7:0]);
   endtask
   task test_edges;
      access(1, 14'h0000, 8'hAA, 1);
      access(1, 14'h3FFF, 8'h55, 1);
      access(0, 14'h0000, 8'h00, 1);
      check("low word", 8'hAA, rdata_out);
      access(0, 14'h3FFF, 8'h00, 1);
      check("top word", 8'h55, rdata_out);
   endtask
   task test_back_to_back;
      access(1, 14'h1234, 8'h3C, 2);
      access(0, 14'h1234, 8'h00, 2);
      check("repeat read", 8'h3C, rdata_out);
   endtask
   // reset cut into a write leaves every strobe idle, then traffic resumes
   task test_reset;
      @(negedge mclk_in);
      {req_in, req_write_in, req_addr_in, req_wdata_in} = {1'b1, 1'b1, 14'h0ABC, 8'h0F};
      @(negedge mclk_in);
      check("busy in access", 8'h01, busy_out);
      rst_n_in = 0;
      req_in = 0;
      @(negedge mclk_in);
      check("select after reset", 8'h01, select_n_out);
      check("strobe after reset", 8'h01, write_n_out);
      check("enable after reset", 8'h01, drive_n_out);
      check("pin drive after reset", 8'h00, oe);
      check("busy after reset", 8'h00, busy_out);
      rst_n_in = 1;
      access(1, 14'h0ABC, 8'hC3, 1);
      access(0, 14'h0ABC, 8'h00, 1);
      check("read after reset", 8'hC3, rdata_out);
   endtask
   task complete_run;
      $display("checks %0d errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   initial begin
      repeat (3) @(negedge mclk_in);
      rst_n_in = 1;
      test_edges;
      test_back_to_back;
      test_reset;
      complete_run;
   end
   // watchdog well past the roughly 75 cycles of traffic
   initial begin
      #20000;
      errors++;
      complete_run;
   end
endmodule // sram_host_tb

// ===== verification/sram_model.sv
// behavioural static memory on the far side of the host controller
`timescale 1ns/1ps
module sram_model (
   input  wire [13:0] word_address_in,
   input  wire        select_n_in,
   input  wire        write_n_in,
   input  wire        drive_n_in,
   input  wire [7:0]  data_in,
   output reg  [7:0]  data_out
);
   reg  [7:0] mem [0:16383];
   wire       rd = !select_n_in && !drive_n_in && write_n_in;
   wire       wr = !select_n_in && !write_n_in;
   wire       echo = wr && !drive_n_in;
   initial data_out = 8'h00;
   // 7 ns response; floating pins show the inverse so stale data never passes
   always @(rd or echo or word_address_in)
      data_out <= #7 rd ? mem[word_address_in] : echo ? data_in : ~data_out;
   // store on whichever strobe rises first
   always @(negedge wr) mem[word_address_in] = data_in;
endmodule // sram_model
